// ==== design/uart_lin_break_controller.sv ====
/*
 UART with baud generator, buffered transmit path, error detection and LIN break.
 Assumes control bits arrive synchronous to i_core_clk and i_rxd is asynchronous.
*/
`timescale 1ns/10ps
module uart_lin_break_controller #(
   parameter int FIFO_DEPTH = uart_lin_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                      i_core_clk,
   input  wire logic                      i_arst_n,
   // Configuration
   input  wire uart_lin_pkg::serial_cfg_s i_cfg,
   // Transmit data stream
   input  wire logic                      i_tx_valid,
   input  wire logic [7:0]                i_tx_data,
   output logic                           o_tx_ready,
   output logic                           o_tx_buffer_full_flag,
   output logic                           o_tx_shift_busy_flag,
   output logic                           o_tx_complete_irq,
   // LIN break control
   input  wire logic                      i_break_tx_trigger,
   input  wire logic                      i_break_rx_trigger,
   input  wire logic                      i_break_flag_clr,
   output logic                           o_break_rx_flag,
   // Receive side
   input  wire logic                      i_err_status_read,
   input  wire logic                      i_rx_buf_read,
   output logic [7:0]                     o_rx_buffer,
   output logic                           o_rx_full,
   output uart_lin_pkg::rx_err_s          o_rx_error_status,
   output logic                           o_bus_wait,
   output logic                           o_rx_done_irq,
   output logic                           o_rx_error_irq,
   // Serial pins
   input  wire logic                      i_rxd,
   output logic                           o_txd
);
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP1, TX_STOP2, TX_BREAK} tx_state_e;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP, RX_BRK_WAIT, RX_BRK_LOW} rx_state_e;

   if (FIFO_DEPTH < 2) begin : g_param_chk
      $error("FIFO_DEPTH must be at least 2");
   end

   logic [uart_lin_pkg::PRE_CNT_W-1:0] pre_cnt;
   logic [uart_lin_pkg::PRE_CNT_W-1:0] pre_mask;
   logic [3:0]                         pre_sel;
   logic                               base_tick;
   logic                               tx_en_s;
   logic                               rx_en_s;
   logic                               rxd_meta;
   logic                               rxd_s;
   logic [uart_lin_pkg::BIT_CNT_W-1:0] bit_full;
   logic [uart_lin_pkg::BIT_CNT_W-1:0] bit_half;
   logic                               fifo_valid;
   logic [7:0]                         fifo_data;
   logic                               fifo_rd_ready;
   logic [7:0]                         tx_buffer;
   tx_state_e                          tx_state;
   logic [uart_lin_pkg::BIT_CNT_W-1:0] tx_cnt;
   logic [3:0]                         tx_bits;
   logic [7:0]                         tx_shift;
   logic                               tx_par;
   logic                               tx_bit_end;
   logic                               tx_load;
   logic                               brk_tx_go;
   logic                               tx_done_ev;
   rx_state_e                          rx_state;
   logic [uart_lin_pkg::BIT_CNT_W-1:0] rx_cnt;
   logic [3:0]                         rx_bits;
   logic [7:0]                         rx_shift;
   logic                               rx_par_in;
   logic                               rx_sample;
   logic                               rx_char_ev;
   logic                               brk_ok_ev;
   logic                               err_armed;
   logic                               rx_clear;
   uart_lin_pkg::rx_err_s              new_err;

   // Base clock: core clock divided by 2^sel, clamped to the supported range
   assign pre_sel   = (i_cfg.prescaler_sel > uart_lin_pkg::PRE_SEL_MAX) ? uart_lin_pkg::PRE_SEL_MAX
                                                                        : i_cfg.prescaler_sel;
   assign pre_mask  = (uart_lin_pkg::PRE_CNT_W'(1) << pre_sel) - uart_lin_pkg::PRE_CNT_W'(1);
   assign base_tick = i_cfg.unit_power_bit && (pre_cnt == pre_mask);

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pre_cnt <= '0;
      end else if (!i_cfg.unit_power_bit || base_tick) begin
         pre_cnt <= '0;
      end else begin
         pre_cnt <= pre_cnt + 1'b1;
      end
   end

   // Enables move on base ticks; a cleared enable holds its state machine idle, but not the FIFO or the receive buffer and flags
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tx_en_s <= 1'b0;
         rx_en_s <= 1'b0;
      end else if (!i_cfg.unit_power_bit) begin
         tx_en_s <= 1'b0;
         rx_en_s <= 1'b0;
      end else if (base_tick) begin
         tx_en_s <= i_cfg.tx_enable_bit;
         rx_en_s <= i_cfg.rx_enable_bit;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rxd_meta <= 1'b1;
         rxd_s    <= 1'b1;
      end else begin
         rxd_meta <= i_rxd;
         rxd_s    <= rxd_meta;
      end
   end

   // One bit is two full passes of the divisor counter
   assign bit_full = {i_cfg.baud_divisor, 1'b0} - uart_lin_pkg::BIT_CNT_W'(1);
   assign bit_half = {1'b0, i_cfg.baud_divisor} - uart_lin_pkg::BIT_CNT_W'(1);

   tx_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_tx_fifo (
      .i_core_clk (i_core_clk),
      .i_arst_n   (i_arst_n),
      .i_wr_valid (i_tx_valid),
      .i_wr_data  (i_tx_data),
      .o_wr_ready (o_tx_ready),
      .o_rd_valid (fifo_valid),
      .o_rd_data  (fifo_data),
      .i_rd_ready (fifo_rd_ready)
   );

   assign fifo_rd_ready = tx_en_s && !o_tx_buffer_full_flag;
   assign brk_tx_go     = tx_en_s && (tx_state == TX_IDLE) && i_break_tx_trigger;
   assign tx_load       = tx_en_s && (tx_state == TX_IDLE) && o_tx_buffer_full_flag && !brk_tx_go;
   assign tx_bit_end    = base_tick && (tx_cnt == bit_full);
   assign tx_done_ev    = tx_en_s && tx_bit_end
                          && (((tx_state == TX_STOP1) && !i_cfg.tx_stop_length_sel) || (tx_state == TX_STOP2));

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tx_buffer             <= '0;
         o_tx_buffer_full_flag <= 1'b0;
      end else if (!tx_en_s) begin
         o_tx_buffer_full_flag <= 1'b0;
      end else if (tx_load) begin
         o_tx_buffer_full_flag <= 1'b0;
      end else if (fifo_valid && fifo_rd_ready) begin
         tx_buffer             <= fifo_data;
         o_tx_buffer_full_flag <= 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tx_state             <= TX_IDLE;
         tx_cnt               <= '0;
         tx_bits              <= '0;
         tx_shift             <= '0;
         tx_par               <= 1'b0;
         o_txd                <= 1'b1;
         o_tx_shift_busy_flag <= 1'b0;
      end else if (!tx_en_s) begin
         tx_state             <= TX_IDLE;
         tx_cnt               <= '0;
         o_txd                <= 1'b1;
         o_tx_shift_busy_flag <= 1'b0;
      end else begin
         if (tx_state == TX_IDLE || tx_bit_end) begin
            tx_cnt <= '0;
         end else if (base_tick) begin
            tx_cnt <= tx_cnt + 1'b1;
         end
         case (tx_state)
            TX_IDLE: begin
               tx_bits <= '0;
               if (brk_tx_go) begin
                  tx_state             <= TX_BREAK;
                  o_txd                <= 1'b0;
                  o_tx_shift_busy_flag <= 1'b1;
               end else if (tx_load) begin
                  tx_state             <= TX_START;
                  tx_shift             <= tx_buffer;
                  tx_par               <= (i_cfg.parity_mode == uart_lin_pkg::PAR_ODD) ? ~^tx_buffer
                                          : (i_cfg.parity_mode == uart_lin_pkg::PAR_EVEN) ? ^tx_buffer : 1'b0;
                  o_txd                <= 1'b0;
                  o_tx_shift_busy_flag <= 1'b1;
               end
            end
            TX_START: begin
               if (tx_bit_end) begin
                  tx_state <= TX_DATA;
                  o_txd    <= tx_shift[0];
               end
            end
            TX_DATA: begin
               if (tx_bit_end) begin
                  if (tx_bits == uart_lin_pkg::LAST_DATA_BIT) begin
                     tx_state <= (i_cfg.parity_mode == uart_lin_pkg::PAR_NONE) ? TX_STOP1 : TX_PARITY;
                     o_txd    <= (i_cfg.parity_mode == uart_lin_pkg::PAR_NONE) ? 1'b1 : tx_par;
                  end else begin
                     tx_shift <= {1'b0, tx_shift[7:1]};
                     o_txd    <= tx_shift[1];
                     tx_bits  <= tx_bits + 1'b1;
                  end
               end
            end
            TX_PARITY: begin
               if (tx_bit_end) begin
                  tx_state <= TX_STOP1;
                  o_txd    <= 1'b1;
               end
            end
            TX_STOP1: begin
               if (tx_bit_end) begin
                  tx_state             <= i_cfg.tx_stop_length_sel ? TX_STOP2 : TX_IDLE;
                  o_tx_shift_busy_flag <= i_cfg.tx_stop_length_sel;
               end
            end
            TX_STOP2: begin
               if (tx_bit_end) begin
                  tx_state             <= TX_IDLE;
                  o_tx_shift_busy_flag <= 1'b0;
               end
            end
            TX_BREAK: begin
               if (tx_bit_end) begin
                  tx_bits <= tx_bits + 1'b1;
                  if (tx_bits == uart_lin_pkg::BRK_TX_BITS - 4'h1) begin
                     tx_state <= TX_STOP1;
                     o_txd    <= 1'b1;
                  end
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end

   // Same pulse ends data frames and break fields alike
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_tx_complete_irq <= 1'b0;
      end else begin
         o_tx_complete_irq <= tx_done_ev;
      end
   end

   assign rx_sample  = base_tick && (rx_cnt == ((rx_state == RX_START) ? bit_half : bit_full));
   assign rx_char_ev = rx_en_s && rx_sample && (rx_state == RX_STOP);
   assign brk_ok_ev  = rx_en_s && (rx_state == RX_BRK_LOW) && rxd_s && (rx_bits >= uart_lin_pkg::BRK_RX_MIN_BITS);

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rx_state  <= RX_IDLE;
         rx_cnt    <= '0;
         rx_bits   <= '0;
         rx_shift  <= '0;
         rx_par_in <= 1'b0;
      end else if (!rx_en_s) begin
         rx_state <= RX_IDLE;
         rx_cnt   <= '0;
      end else begin
         if (rx_state == RX_IDLE || rx_state == RX_BRK_WAIT || rx_sample) begin
            rx_cnt <= '0;
         end else if (base_tick) begin
            rx_cnt <= rx_cnt + 1'b1;
         end
         case (rx_state)
            RX_IDLE: begin
               rx_bits <= '0;
               if (i_break_rx_trigger) begin
                  rx_state <= RX_BRK_WAIT;
               end else if (!rxd_s) begin
                  rx_state <= RX_START;
               end
            end
            RX_START: begin
               if (rx_sample) begin
                  rx_state <= rxd_s ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (rx_sample) begin
                  rx_shift <= {rxd_s, rx_shift[7:1]};
                  rx_bits  <= rx_bits + 1'b1;
                  if (rx_bits == uart_lin_pkg::LAST_DATA_BIT) begin
                     rx_state <= (i_cfg.parity_mode == uart_lin_pkg::PAR_NONE) ? RX_STOP : RX_PARITY;
                  end
               end
            end
            RX_PARITY: begin
               if (rx_sample) begin
                  rx_par_in <= rxd_s;
                  rx_state  <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (rx_sample) begin
                  rx_state <= RX_IDLE;
               end
            end
            RX_BRK_WAIT: begin
               rx_bits <= '0;
               if (!rxd_s) begin
                  rx_state <= RX_BRK_LOW;
               end
            end
            RX_BRK_LOW: begin
               if (rxd_s) begin
                  rx_state <= brk_ok_ev ? RX_IDLE : RX_BRK_WAIT;
               end else if (rx_sample && rx_bits != 4'hF) begin
                  rx_bits <= rx_bits + 1'b1;
               end
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

   always_comb begin
      new_err.overrun           = o_rx_full;
      new_err.framing           = !rxd_s;
      new_err.parity_error_flag = ((i_cfg.parity_mode == uart_lin_pkg::PAR_ODD) && !(^{rx_shift, rx_par_in}))
                                  || ((i_cfg.parity_mode == uart_lin_pkg::PAR_EVEN) && (^{rx_shift, rx_par_in}));
   end

   // A buffer read alone never clears a pending error
   assign rx_clear = i_rx_buf_read && err_armed;

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rx_error_status <= '0;
         err_armed         <= 1'b0;
         o_bus_wait        <= 1'b0;
      end else begin
         o_bus_wait <= i_err_status_read;
         err_armed  <= i_err_status_read || (err_armed && !i_rx_buf_read);
         o_rx_error_status <= (o_rx_error_status & {3{!rx_clear}}) | (rx_char_ev ? new_err : '0);
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rx_buffer <= '0;
         o_rx_full   <= 1'b0;
      end else if (rx_char_ev && !o_rx_full) begin
         o_rx_buffer <= rx_shift;
         o_rx_full   <= 1'b1;
      end else if (i_rx_buf_read && ((o_rx_error_status == '0) || err_armed)) begin
         o_rx_full <= 1'b0;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rx_done_irq   <= 1'b0;
         o_rx_error_irq  <= 1'b0;
         o_break_rx_flag <= 1'b0;
      end else begin
         o_rx_done_irq   <= brk_ok_ev || (rx_char_ev && ((new_err == '0) || !i_cfg.rx_error_irq_mode));
         o_rx_error_irq  <= rx_char_ev && (new_err != '0) && i_cfg.rx_error_irq_mode;
         o_break_rx_flag <= brk_ok_ev || (o_break_rx_flag && !i_break_flag_clr);
      end
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_arst_n);

   one_stop_a: assert property ((rx_state == RX_STOP) && rx_sample |=> rx_state == RX_IDLE)
      else $error("receiver did not end the frame after one stop bit");
   parity_mode_a: assert property ($rose(o_rx_error_status.parity_error_flag) |-> $past(i_cfg.parity_mode[1]))
      else $error("parity error raised without odd or even parity");
   framing_first_a: assert property (rx_char_ev && !rxd_s |=> o_rx_error_status.framing)
      else $error("low first stop bit not flagged as framing error");
   overrun_keep_a: assert property (rx_char_ev && o_rx_full |=> $stable(o_rx_buffer) && o_rx_error_status.overrun)
      else $error("overrun did not keep the old buffer and flag");
   status_wait_a: assert property (i_err_status_read |=> o_bus_wait ##1 !o_bus_wait || $past(i_err_status_read))
      else $error("error status read did not give one wait cycle");
   break_fail_a: assert property ((rx_state == RX_BRK_LOW) && rxd_s && (rx_bits < uart_lin_pkg::BRK_RX_MIN_BITS)
                                  && rx_en_s && i_cfg.rx_enable_bit && i_cfg.unit_power_bit && !i_break_flag_clr
                                  |=> (rx_state == RX_BRK_WAIT) && $stable(o_break_rx_flag))
      else $error("failed break did not return to waiting with flag held");
   tx_done_a: assert property (tx_done_ev |=> o_tx_complete_irq && (tx_state == TX_IDLE))
      else $error("transmit end not followed by complete pulse");
   buf_move_a: assert property (tx_load |=> !o_tx_buffer_full_flag && o_tx_shift_busy_flag)
      else $error("buffer full or busy flag wrong after load to shifter");
endmodule : uart_lin_break_controller

// ==== design/uart_lin_pkg.sv ====
/*
 Shared constants and carrier types for the LIN-capable UART.
 Assumes every user writes uart_lin_pkg::name; nothing is imported.
*/
package uart_lin_pkg;
   localparam int         DATA_BITS       = 8;
   localparam int         DIV_W           = 8;
   localparam int         BIT_CNT_W       = 9;
   localparam int         PRE_CNT_W       = 11;
   localparam int         FIFO_DEPTH      = 16;
   localparam logic [3:0] PRE_SEL_MAX     = 4'hA;
   localparam logic [1:0] PAR_NONE        = 2'h0;
   localparam logic [1:0] PAR_ZERO        = 2'h1;
   localparam logic [1:0] PAR_ODD         = 2'h2;
   localparam logic [1:0] PAR_EVEN        = 2'h3;
   localparam logic [3:0] LAST_DATA_BIT   = 4'h7;
   localparam logic [3:0] BRK_TX_BITS     = 4'hD;
   localparam logic [3:0] BRK_RX_MIN_BITS = 4'hB;

   typedef struct packed {
      logic       unit_power_bit;
      logic       tx_enable_bit;
      logic       rx_enable_bit;
      logic       tx_stop_length_sel;
      logic       rx_error_irq_mode;
      logic [1:0] parity_mode;
      logic [3:0] prescaler_sel;
      logic [7:0] baud_divisor;
   } serial_cfg_s;

   typedef struct packed {
      logic overrun;
      logic framing;
      logic parity_error_flag;
   } rx_err_s;
endpackage : uart_lin_pkg

// ==== design/tx_fifo.sv ====
/*
 Synchronous FIFO with a registered read stage and registered write ready.
 Assumes one clock and a depth that is a power of two.
*/
`timescale 1ns/10ps
module tx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             i_core_clk,
   input  wire logic             i_arst_n,
   // Fill side
   input  wire logic             i_wr_valid,
   input  wire logic [WIDTH-1:0] i_wr_data,
   output logic                  o_wr_ready,
   // Drain side
   output logic                  o_rd_valid,
   output logic      [WIDTH-1:0] o_rd_data,
   input  wire logic             i_rd_ready
);
   localparam int AW = $clog2(DEPTH);

   if ((DEPTH < 2) || ((DEPTH & (DEPTH - 1)) != 0)) begin : g_depth_chk
      $error("tx_fifo depth must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW:0]      next_count;
   logic             wr_fire;
   logic             load;

   assign wr_fire = i_wr_valid && o_wr_ready;
   assign load    = (count != '0) && (!o_rd_valid || i_rd_ready);

   always_comb begin
      next_count = count;
      if (wr_fire && !load) begin
         next_count = count + 1'b1;
      end else if (!wr_fire && load) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (wr_fire) begin
         mem[wr_ptr] <= i_wr_data;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wr_ptr     <= '0;
         rd_ptr     <= '0;
         count      <= '0;
         o_wr_ready <= 1'b1;
      end else begin
         count      <= next_count;
         o_wr_ready <= next_count != (AW+1)'(DEPTH);
         if (wr_fire) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (load) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end

   // Read data always leaves from a register so the consumer sees no memory path
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rd_valid <= 1'b0;
         o_rd_data  <= '0;
      end else if (load) begin
         o_rd_valid <= 1'b1;
         o_rd_data  <= mem[rd_ptr];
      end else if (i_rd_ready) begin
         o_rd_valid <= 1'b0;
      end
   end
endmodule : tx_fifo

// ==== dv/serial_node.sv ====
/* Remote serial node: drives frames and breaks onto i_rxd, samples o_txd.
   Assumes a bit time of BIT core cycles and an idle-high line. */
`timescale 1ns/10ps
module serial_node #(
   parameter int BIT = 8
) (
   // Clock
   input  wire logic i_core_clk,
   // Serial lines
   input  wire logic i_txd,
   output logic      o_rxd
);
   initial o_rxd = 1'b1;
   task automatic put(input logic v, input int n);
      #1 o_rxd = v;
      repeat (n * BIT) @(posedge i_core_clk);
   endtask : put
   // Start, data LSB first, optional parity, one stop, one idle bit
   task automatic send(input logic [7:0] d, input int p, input logic stp);
      put(1'b0, 1);
      for (int i = 0; i < 8; i++) put(d[i], 1);
      if (p >= 0) put(p[0], 1);
      put(stp, 1);
      put(1'b1, 1);
   endtask : send
   task automatic brk(input int n);
      put(1'b0, n);
      put(1'b1, 2);
   endtask : brk
   // Mid-bit sampling, so a wrong bit time shows as wrong bits
   task automatic grab(output logic [10:0] f);
      for (int k = 0; k < 3000 && i_txd; k++) @(posedge i_core_clk);
      repeat (BIT / 2) @(posedge i_core_clk);
      for (int i = 0; i < 11; i++) begin
         #1 f[i] = i_txd;
         repeat (BIT) @(posedge i_core_clk);
      end
   endtask : grab
endmodule : serial_node

// ==== dv/uart_lin_break_controller_bench.sv ====
/* Self-checking bench for the LIN-capable UART.
   Assumes prescaler 0 and divisor 4, so one bit lasts 8 core cycles. */
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module uart_lin_break_controller_bench;
   typedef struct packed {logic [7:0] d; logic [1:0] pm; logic flip; logic stp; logic [2:0] err;} row_s;
   logic i_core_clk = 0, i_arst_n = 0, i_tx_valid = 0, i_break_tx_trigger = 0, i_break_rx_trigger = 0;
   logic i_break_flag_clr = 0, i_err_status_read = 0, i_rx_buf_read = 0, o_tx_ready, o_txd, rxd;
   logic o_tx_buffer_full_flag, o_tx_shift_busy_flag, o_tx_complete_irq, o_break_rx_flag, o_rx_full;
   logic o_bus_wait, o_rx_done_irq, o_rx_error_irq;
   logic [7:0] i_tx_data = 8'h00, o_rx_buffer;
   logic [10:0] f;
   uart_lin_pkg::serial_cfg_s cfg = '0;
   uart_lin_pkg::rx_err_s o_rx_error_status;
   int failures = 0, total_checks = 0, n_rx = 0, n_tx = 0, n_err = 0, cyc = 0, t, k, e;
   row_s rows[7] = '{'{8'hA5, 2'h0, 1'b0, 1'b1, 3'h0}, '{8'h3C, 2'h1, 1'b1, 1'b1, 3'h0},
      '{8'h5A, 2'h2, 1'b0, 1'b1, 3'h0}, '{8'h5A, 2'h2, 1'b1, 1'b1, 3'h1}, '{8'h81, 2'h3, 1'b0, 1'b1, 3'h0},
      '{8'h81, 2'h3, 1'b1, 1'b1, 3'h1}, '{8'hFF, 2'h3, 1'b0, 1'b0, 3'h2}};
   uart_lin_break_controller uart_lin_break_controller_i (.i_core_clk, .i_arst_n, .i_cfg(cfg), .i_tx_valid,
      .i_tx_data, .o_tx_ready, .o_tx_buffer_full_flag, .o_tx_shift_busy_flag, .o_tx_complete_irq,
      .i_break_tx_trigger, .i_break_rx_trigger, .i_break_flag_clr, .o_break_rx_flag, .i_err_status_read,
      .i_rx_buf_read, .o_rx_buffer, .o_rx_full, .o_rx_error_status, .o_bus_wait, .o_rx_done_irq,
      .o_rx_error_irq, .i_rxd(rxd), .o_txd);
   serial_node serial_node_i (.i_core_clk, .i_txd(o_txd), .o_rxd(rxd));
   initial forever #4 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk) begin
      n_rx += int'(o_rx_done_irq === 1'b1 || o_rx_error_irq === 1'b1);
      n_tx += int'(o_tx_complete_irq === 1'b1);
      n_err += int'(o_rx_error_irq === 1'b1);
      if (++cyc == 20000) begin
         failures++;
         summarize();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask : tick
   task automatic waitc(ref int c, input int v);
      for (int j = 0; j < 4000 && c < v; j++) tick(1);
   endtask : waitc
   // Enables dropped around a format change, then held off one base clock
   task automatic setcfg(input logic [1:0] pm, input logic en, input logic sl = 1'b0);
      cfg.tx_enable_bit = 0;
      cfg.rx_enable_bit = 0;
      tick(3);
      cfg.parity_mode = pm;
      cfg.tx_stop_length_sel = sl;
      tick(1);
      cfg.tx_enable_bit = en;
      cfg.rx_enable_bit = en;
      tick(3);
   endtask : setcfg
   task automatic clr();
      i_err_status_read = 1;
      tick(1);
      i_err_status_read = 0;
      `CHK(o_bus_wait, 1'b1)
      i_rx_buf_read = 1;
      tick(1);
      i_rx_buf_read = 0;
      tick(1);
      `CHK({o_rx_full, o_rx_error_status}, 4'h0)
   endtask : clr
   function automatic int pbit(row_s r);
      case (r.pm)
         2'h0: return -1;
         2'h1: return int'(r.flip);
         2'h2: return int'(~^r.d ^ r.flip);
         default: return int'(^r.d ^ r.flip);
      endcase
   endfunction : pbit
   task automatic summarize();
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : summarize
   initial begin
      cfg.unit_power_bit = 1;
      cfg.rx_error_irq_mode = 1;
      cfg.baud_divisor = 8'h04;
      tick(3);
      `CHK({o_txd, o_tx_ready, o_rx_full, o_break_rx_flag}, 4'hC) // [reset]
      i_arst_n = 1;
      tick(2);
      foreach (rows[r]) begin
         setcfg(rows[r].pm, 1);
         t = n_rx;
         e = n_err;
         serial_node_i.send(rows[r].d, pbit(rows[r]), rows[r].stp);
         tick(2);
         `CHK(o_rx_error_status, rows[r].err)
         if (rows[r].err == 3'h0) `CHK(o_rx_buffer, rows[r].d)
         `CHK(n_rx, t + 1)
         `CHK(n_err - e, int'(rows[r].err != 3'h0))
         clr();
      end
      serial_node_i.send(8'hA5, int'(^8'hA5), 1'b1);
      serial_node_i.send(8'h5A, int'(^8'h5A), 1'b1);
      tick(2);
      `CHK(o_rx_error_status, 3'h4)
      `CHK(o_rx_buffer, 8'hA5)
      clr();
      setcfg(2'h3, 1, 1);
      t = n_tx;
      i_tx_valid = 1;
      i_tx_data = 8'hC3;
      tick(1);
      i_tx_valid = 0;
      serial_node_i.grab(f);
      `CHK(f, {1'b1, ^8'hC3, 8'hC3, 1'b0})
      // Two stop bits: the shifter is still busy after the first one ends
      tick(1);
      `CHK({o_tx_shift_busy_flag, n_tx == t}, 2'h3)
      waitc(n_tx, t + 1);
      `CHK(o_tx_shift_busy_flag, 1'b0)
      t = n_tx;
      i_break_tx_trigger = 1;
      tick(1);
      i_break_tx_trigger = 0;
      for (k = 0; k < 50 && o_txd; k++) tick(1);
      for (k = 0; k < 300 && !o_txd; k++) tick(1);
      `CHK(4'((k + 4) / 8), uart_lin_pkg::BRK_TX_BITS)
      waitc(n_tx, t + 1);
      `CHK(n_tx, t + 1)
      // Transmit off: the FIFO keeps filling until it refuses
      setcfg(2'h3, 0);
      i_tx_valid = 1;
      t = 0;
      for (k = 0; k < 40; k++) begin
         @(posedge i_core_clk);
         t += int'(o_tx_ready === 1'b1);
      end
      #1 i_tx_valid = 0;
      `CHK(o_tx_ready, 1'b0)
      `CHK(t, uart_lin_pkg::FIFO_DEPTH + 1)
      t = t + n_tx;
      setcfg(2'h3, 1);
      tick(2);
      `CHK({o_tx_buffer_full_flag, o_tx_shift_busy_flag}, 2'h3)
      waitc(n_tx, t);
      tick(200);
      `CHK(n_tx, t)
      setcfg(2'h0, 1);
      foreach (rows[r]) if (r < 2) begin
         i_break_rx_trigger = 1;
         tick(1);
         i_break_rx_trigger = 0;
         serial_node_i.brk(r == 0 ? 13 : 5);
         `CHK(o_break_rx_flag, 1'b1)
      end
      i_break_flag_clr = 1;
      tick(1);
      i_break_flag_clr = 0;
      tick(1);
      `CHK(o_break_rx_flag, 1'b0)
      summarize();
   end
endmodule : uart_lin_break_controller_bench
